// [design/drp_defs.svh]
// register indices, field positions, reset values and bus codes of the profile bank
`ifndef DRP_DEFS_SVH
`define DRP_DEFS_SVH

// register indices (byte address is four times the index)
`define DRP_IDX_PRIO_EN      16'h0467
`define DRP_IDX_BW_LOW       16'h0468
`define DRP_IDX_BW_MID       16'h0469
`define DRP_IDX_BW_HIGH_FILT 16'h046a
`define DRP_IDX_INT_LOW      16'h046b
`define DRP_IDX_INT_MID      16'h046c
`define DRP_IDX_INT_HIGH     16'h046d
`define DRP_IDX_NUM_LOW      16'h046e
`define DRP_IDX_NUM_MID      16'h046f
`define DRP_IDX_NUM_HIGH     16'h0470
`define DRP_IDX_MOD_LOW      16'h0471
`define DRP_IDX_MOD_MID      16'h0472
`define DRP_IDX_MOD_HIGH     16'h0473

// second loop mirror banks: control, analog plus sync, reference profiles
`define DRP_IDX_MIR_CTRL_FIRST 16'h0500
`define DRP_IDX_MIR_CTRL_LAST  16'h051e
`define DRP_IDX_MIR_ANA_FIRST  16'h0530
`define DRP_IDX_MIR_ANA_LAST   16'h053e
`define DRP_IDX_MIR_REF_FIRST  16'h0540
`define DRP_IDX_MIR_REF_LAST   16'h0559

// storage slots
`define DRP_SLOTS         85
`define DRP_SLOT_MIR_CTRL 7'h0d
`define DRP_SLOT_MIR_ANA  7'h2c
`define DRP_SLOT_MIR_REF  7'h3b

// field positions and writable masks
`define DRP_EN_BIT     0
`define DRP_PRIO_LSB   1
`define DRP_BW16_BIT   0
`define DRP_FILT_BIT   1
`define DRP_MASK_PRIO  8'h07
`define DRP_MASK_BWHI  8'h03
`define DRP_MASK_INTHI 8'h03
`define DRP_MASK_FULL  8'hff

// reset values
`define DRP_PROFILE_RST 8'h00
`define DRP_MIRROR_RST  8'h00

// bus answers
`define DRP_RESP_OKAY   2'h0
`define DRP_RESP_SLVERR 2'h2

`endif

// [design/drp_pkg.sv]
// types shared by the reference profile register bank
package drp_pkg;

    typedef enum logic [0:0] {
        DRP_RD_IDLE,
        DRP_RD_RESP
    } drp_rd_state_t;

    typedef logic [7:0] drp_byte_t;

    // slot lookup result: hit flag and storage slot
    typedef struct packed {
        logic hit;
        logic [6:0] slot;
    } drp_slot_t;

endpackage

// [design/drp_ref_profile_regs.sv]
// fourth reference lock profile of the first digital loop, with second loop mirror banks
// ============================================================================
// Summary of operation
// - two-bit priority in bits 2:1, code 00 highest, 11 lowest, resets 00.
// - bit 0 lets the first digital loop lock to the fourth reference; resets 0.
// - seventeen-bit bandwidth in 0.1 Hz units over three registers, resets zero.
// - bit 1 of third bandwidth register picks high phase margin filter, 0 normal.
// - eighteen-bit integer feedback ratio minus one over three registers, resets zero.
// - twenty-four-bit fractional numerator, three bytes, low byte first, resets zero.
// - twenty-four-bit fractional modulus, three bytes, low byte first, resets zero.
// - second loop control bank mirrors first loop bank, raised by 0x0100.
// - second analog loop configuration mirrors first, raised by 0x0100.
// - second output sync and distribution bank mirrors first, raised by 0x0100.
// - second loop first-reference profile mirrors first loop bank, raised 0x0100.
// - second loop second-reference profile mirrors first loop bank, raised 0x0100.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "drp_defs.svh"

module drp_ref_profile_regs #(
    // reset value of the mirrored banks; copies the first loop defaults
    parameter logic [7:0] MIRROR_DEFAULT = `DRP_MIRROR_RST
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // axi4-lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // enables and priorities of first, second and third references
    input wire logic [2:0] other_ref_enable,
    input wire logic [5:0] other_ref_priority,
    // reference choice of the first digital loop
    output logic sel_valid,
    output logic [1:0] sel_ref,
    // settings applied while the fourth reference is chosen
    output logic apply_active,
    output logic [16:0] loop_bandwidth,
    output logic filter_high_pm,
    output logic [18:0] integer_feedback_ratio,
    output logic [23:0] fractional_numerator,
    output logic [23:0] fractional_modulus
);

    // ========================================================================
    // address decode and write masks

    function automatic drp_pkg::drp_slot_t drp_decode(input logic [15:0] byte_addr);
        logic [15:0] idx;
        drp_pkg::drp_slot_t res;
        idx = {2'b00, byte_addr[15:2]};
        res = '0;
        if (idx >= `DRP_IDX_PRIO_EN && idx <= `DRP_IDX_MOD_HIGH) begin
            res.hit = 1'b1;
            res.slot = 7'(idx - `DRP_IDX_PRIO_EN);
        end else if (idx >= `DRP_IDX_MIR_CTRL_FIRST && idx <= `DRP_IDX_MIR_CTRL_LAST) begin
            res.hit = 1'b1;
            res.slot = 7'(idx - `DRP_IDX_MIR_CTRL_FIRST) + `DRP_SLOT_MIR_CTRL;
        end else if (idx >= `DRP_IDX_MIR_ANA_FIRST && idx <= `DRP_IDX_MIR_ANA_LAST) begin
            res.hit = 1'b1;
            res.slot = 7'(idx - `DRP_IDX_MIR_ANA_FIRST) + `DRP_SLOT_MIR_ANA;
        end else if (idx >= `DRP_IDX_MIR_REF_FIRST && idx <= `DRP_IDX_MIR_REF_LAST) begin
            res.hit = 1'b1;
            res.slot = 7'(idx - `DRP_IDX_MIR_REF_FIRST) + `DRP_SLOT_MIR_REF;
        end
        return res;
    endfunction

    // reserved bits of the profile never store, so they read back as zero
    function automatic logic [7:0] drp_mask(input logic [6:0] slot);
        logic [7:0] m;
        m = `DRP_MASK_FULL;
        if (slot == 7'(`DRP_IDX_PRIO_EN - `DRP_IDX_PRIO_EN)) begin
            m = `DRP_MASK_PRIO;
        end else if (slot == 7'(`DRP_IDX_BW_HIGH_FILT - `DRP_IDX_PRIO_EN)) begin
            m = `DRP_MASK_BWHI;
        end else if (slot == 7'(`DRP_IDX_INT_HIGH - `DRP_IDX_PRIO_EN)) begin
            m = `DRP_MASK_INTHI;
        end
        return m;
    endfunction

    // ========================================================================
    // write channel

    drp_pkg::drp_byte_t mem [`DRP_SLOTS];
    drp_pkg::drp_byte_t next_mem [`DRP_SLOTS];
    logic aw_got, next_aw_got;
    logic w_got, next_w_got;
    logic [15:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic aw_have, w_have, wr_fire;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    drp_pkg::drp_slot_t wr_dec;

    assign s_axi_awready = !aw_got && !bvalid;
    assign s_axi_wready = !w_got && !bvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;

    // address and data are taken in either order; the write lands once both are here
    assign aw_have = aw_got || (s_axi_awvalid && s_axi_awready);
    assign w_have = w_got || (s_axi_wvalid && s_axi_wready);
    assign wr_fire = aw_have && w_have && !bvalid;
    assign wr_addr = aw_got ? aw_addr : s_axi_awaddr;
    assign wr_data = w_got ? w_data : s_axi_wdata;
    assign wr_strb = w_got ? w_strb : s_axi_wstrb;
    assign wr_dec = drp_decode(wr_addr);

    always_comb begin
        next_mem = mem;
        next_aw_got = aw_have;
        next_w_got = w_have;
        next_aw_addr = aw_got ? aw_addr : s_axi_awaddr;
        next_w_data = w_got ? w_data : s_axi_wdata;
        next_w_strb = w_got ? w_strb : s_axi_wstrb;
        next_bvalid = bvalid && !s_axi_bready;
        next_bresp = bresp;
        if (wr_fire) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_dec.hit ? `DRP_RESP_OKAY : `DRP_RESP_SLVERR;
            // narrow registers sit in byte lane 0 only
            if (wr_dec.hit && wr_strb[0]) begin
                next_mem[wr_dec.slot] = wr_data[7:0] & drp_mask(wr_dec.slot);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `DRP_SLOTS; i++) begin
                // mirror banks start with the same defaults as their originals
                mem[i] <= (i < `DRP_SLOT_MIR_CTRL) ? `DRP_PROFILE_RST : MIRROR_DEFAULT;
            end
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 16'h0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `DRP_RESP_OKAY;
        end else begin
            mem <= next_mem;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // ========================================================================
    // read channel

    drp_pkg::drp_rd_state_t rd_state, next_rd_state;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    drp_pkg::drp_slot_t rd_dec;

    assign s_axi_arready = (rd_state == drp_pkg::DRP_RD_IDLE);
    assign s_axi_rvalid = (rd_state == drp_pkg::DRP_RD_RESP);
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign rd_dec = drp_decode(s_axi_araddr);

    always_comb begin
        next_rd_state = rd_state;
        next_rdata = rdata;
        next_rresp = rresp;
        case (rd_state)
            drp_pkg::DRP_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = drp_pkg::DRP_RD_RESP;
                    // mirrors read back their own storage
                    next_rdata = rd_dec.hit ? {24'h00_0000, mem[rd_dec.slot]} : 32'h0000_0000;
                    next_rresp = rd_dec.hit ? `DRP_RESP_OKAY : `DRP_RESP_SLVERR;
                end
            end
            drp_pkg::DRP_RD_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = drp_pkg::DRP_RD_IDLE;
                end
            end
            default: begin
                next_rd_state = drp_pkg::DRP_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_state <= drp_pkg::DRP_RD_IDLE;
            rdata <= 32'h0000_0000;
            rresp <= `DRP_RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ========================================================================
    // profile fields

    logic ref_enable;
    logic [1:0] prio_code;
    logic [16:0] bw_field;
    logic filt_field;
    logic [17:0] int_field;
    logic [23:0] num_field;
    logic [23:0] mod_field;

    assign ref_enable = mem[0][`DRP_EN_BIT];
    assign prio_code = mem[0][`DRP_PRIO_LSB +: 2];
    assign bw_field = {mem[3][`DRP_BW16_BIT], mem[2], mem[1]};
    assign filt_field = mem[3][`DRP_FILT_BIT];
    assign int_field = {mem[6][1:0], mem[5], mem[4]};
    assign num_field = {mem[9], mem[8], mem[7]};
    assign mod_field = {mem[12], mem[11], mem[10]};

    // ========================================================================
    // reference choice and applied settings

    logic next_sel_valid;
    logic [1:0] next_sel_ref;
    logic next_apply_active;
    logic [16:0] next_loop_bandwidth;
    logic next_filter_high_pm;
    logic [18:0] next_integer_feedback_ratio;
    logic [23:0] next_fractional_numerator;
    logic [23:0] next_fractional_modulus;

    always_comb begin
        logic [3:0] en;
        logic [7:0] pr;
        logic [1:0] best;
        en = {ref_enable, other_ref_enable};
        pr = {prio_code, other_ref_priority};
        best = 2'd3;
        next_sel_valid = 1'b0;
        next_sel_ref = 2'd0;
        // ties go to the lower-numbered reference
        for (int i = 0; i < 4; i++) begin
            if (en[i] && (!next_sel_valid || pr[2 * i +: 2] < best)) begin
                next_sel_valid = 1'b1;
                next_sel_ref = 2'(i);
                best = pr[2 * i +: 2];
            end
        end
        next_apply_active = next_sel_valid && (next_sel_ref == 2'd3);
        next_loop_bandwidth = 17'h0_0000;
        next_filter_high_pm = 1'b0;
        next_integer_feedback_ratio = 19'h0_0000;
        next_fractional_numerator = 24'h00_0000;
        next_fractional_modulus = 24'h00_0000;
        if (next_apply_active) begin
            next_loop_bandwidth = bw_field;
            next_filter_high_pm = filt_field;
            next_integer_feedback_ratio = {1'b0, int_field} + 19'h0_0001;
            next_fractional_numerator = num_field;
            next_fractional_modulus = mod_field;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_valid <= 1'b0;
            sel_ref <= 2'd0;
            apply_active <= 1'b0;
            loop_bandwidth <= 17'h0_0000;
            filter_high_pm <= 1'b0;
            integer_feedback_ratio <= 19'h0_0000;
            fractional_numerator <= 24'h00_0000;
            fractional_modulus <= 24'h00_0000;
        end else begin
            sel_valid <= next_sel_valid;
            sel_ref <= next_sel_ref;
            apply_active <= next_apply_active;
            loop_bandwidth <= next_loop_bandwidth;
            filter_high_pm <= next_filter_high_pm;
            integer_feedback_ratio <= next_integer_feedback_ratio;
            fractional_numerator <= next_fractional_numerator;
            fractional_modulus <= next_fractional_modulus;
        end
    end

    // ========================================================================
    // checks

    default clocking drp_cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // helper: slot decoded from the write address one cycle earlier, taken every cycle
    logic [6:0] last_slot;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_slot <= 7'h00;
        end else begin
            last_slot <= wr_dec.slot;
        end
    end

    chk_prio_store: assert property (
        (wr_fire && wr_dec.hit && wr_strb[0] && wr_dec.slot == 7'h00)
        |=> prio_code == $past(wr_data[2:1]) && mem[0][7:3] == 5'h00)
        else $error("priority field not stored from bits 2:1");

    chk_enable_gate: assert property (
        !ref_enable |=> !(sel_valid && sel_ref == 2'd3))
        else $error("fourth reference chosen while disabled");

    chk_bw_apply: assert property (
        apply_active |-> loop_bandwidth == $past(bw_field))
        else $error("applied bandwidth differs from profile");

    chk_filter_apply: assert property (
        apply_active |-> filter_high_pm == $past(filt_field))
        else $error("applied filter choice differs from profile");

    chk_int_ratio: assert property (
        apply_active |-> integer_feedback_ratio == {1'b0, $past(int_field)} + 19'h0_0001)
        else $error("integer ratio is not stored value plus one");

    chk_frac_apply: assert property (
        apply_active |-> fractional_numerator == $past(num_field)
        && fractional_modulus == $past(mod_field))
        else $error("fractional settings not applied");

    chk_mirror_write: assert property (
        (wr_fire && wr_dec.hit && wr_strb[0] && wr_dec.slot >= `DRP_SLOT_MIR_CTRL)
        |=> mem[last_slot] == $past(wr_data[7:0]))
        else $error("mirror byte not stored whole");

    chk_sel_lowest: assert property (
        (ref_enable && prio_code == 2'b00 && other_ref_enable == 3'b000) |=> apply_active)
        else $error("only enabled reference not chosen");

    chk_write_resp: assert property (
        wr_fire |=> s_axi_bvalid
        && s_axi_bresp == ($past(wr_dec.hit) ? `DRP_RESP_OKAY : `DRP_RESP_SLVERR))
        else $error("write answer missing or wrong after both channels");

    chk_resp_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before it was taken");

    chk_read_answer: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid
        && s_axi_rresp == ($past(rd_dec.hit) ? `DRP_RESP_OKAY : `DRP_RESP_SLVERR))
        else $error("read answer wrong or late");

    chk_none_enabled: assert property (
        (!ref_enable && other_ref_enable == 3'b000) |=> !sel_valid ##0 !apply_active)
        else $error("selection with no enabled reference");

    cov_fourth_applied: cover property (!apply_active ##1 apply_active);
    cov_mirror_write: cover property (wr_fire && wr_dec.slot >= `DRP_SLOT_MIR_REF);
    cov_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == `DRP_RESP_SLVERR);
    cov_resp_stall: cover property (s_axi_bvalid && !s_axi_bready ##1 s_axi_bvalid);

endmodule

// [tb/dpll_ref_profile_regs_bench.sv]
// self-checking bench of the fourth reference profile bank against a byte model
`timescale 1ns/100ps
`include "drp_defs.svh"

module dpll_ref_profile_regs_bench;
    logic ref_clk, rst_b;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, sel_ref;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0] other_ref_enable;
    logic [5:0] other_ref_priority;
    logic sel_valid, apply_active, filter_high_pm;
    logic [16:0] loop_bandwidth;
    logic [18:0] integer_feedback_ratio;
    logic [23:0] fractional_numerator, fractional_modulus;
    int n_errors, tests_run, seed_ret, idx;
    logic [7:0] mdl [int];
    int idx_list[$];

    drp_ref_profile_regs drp_ref_profile_regs_inst (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .other_ref_enable(other_ref_enable), .other_ref_priority(other_ref_priority),
        .sel_valid(sel_valid), .sel_ref(sel_ref), .apply_active(apply_active),
        .loop_bandwidth(loop_bandwidth), .filter_high_pm(filter_high_pm),
        .integer_feedback_ratio(integer_feedback_ratio),
        .fractional_numerator(fractional_numerator), .fractional_modulus(fractional_modulus)
    );

    // ============================================================
    // clock and verdict
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        n_errors++;
        $display("mismatch at %0t: no answer to %s", $time, what);
        results();
    endtask

    // ============================================================
    // reference model of the byte map
    function automatic logic mapped(input int i);
        return (i >= 'h467 && i <= 'h473) || (i >= 'h500 && i <= 'h51e) ||
            (i >= 'h530 && i <= 'h53e) || (i >= 'h540 && i <= 'h559);
    endfunction

    function automatic logic [7:0] wmask(input int i);
        // reserved bits above the priority, bandwidth bit 16 plus filter, divider bits 17:16
        if (i == 'h467) return 8'h07;
        if (i == 'h46a || i == 'h46d) return 8'h03;
        return 8'hff;
    endfunction

    function automatic logic [7:0] mb(input int i);
        return mdl.exists(i) ? mdl[i] : 8'h00;
    endfunction

    // ============================================================
    // bus master: handshakes judged on settled values before each rising edge
    task automatic bus_write(input int i, input logic [7:0] d, input logic strb);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] resp;
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= 16'(i * 4);
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'($urandom), d};
        s_axi_wstrb <= {3'($urandom), strb};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge ref_clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang("write");
        if (strb && mapped(i)) mdl[i] = d & wmask(i);
        check(32'(resp), mapped(i) ? `DRP_RESP_OKAY : `DRP_RESP_SLVERR, "write resp");
    endtask

    task automatic check_reg(input int i);
        logic ar_hs, r_hs;
        logic [31:0] data;
        logic [1:0] resp;
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= 16'(i * 4);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid && s_axi_rready;
            data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge ref_clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang("read");
        check(32'(resp), mapped(i) ? `DRP_RESP_OKAY : `DRP_RESP_SLVERR, "read resp");
        check(data, {24'h00_0000, mb(i)}, "read data");
    endtask

    task automatic check_sel;
        logic ens[4];
        logic [1:0] pri[4];
        logic four;
        int best;
        // inputs driven at the call's edge settle before the model reads them
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        for (int k = 0; k < 3; k++) begin
            ens[k] = other_ref_enable[k];
            pri[k] = other_ref_priority[2 * k +: 2];
        end
        ens[3] = mb('h467) & 8'h01;
        pri[3] = mb('h467) >> 1;
        best = -1;
        for (int k = 0; k < 4; k++) begin
            if (ens[k] && (best < 0 || pri[k] < pri[best])) best = k;
        end
        four = (best == 3);
        check(32'(sel_valid), 32'(best >= 0), "sel valid");
        if (best >= 0) check(32'(sel_ref), 32'(best), "sel ref");
        check(32'(apply_active), 32'(four), "apply");
        check(32'(loop_bandwidth), four ? {mb('h46a) & 8'h01, mb('h469), mb('h468)} : 0, "bw");
        check(32'(filter_high_pm), four ? 32'(mb('h46a) >> 1) : 0, "filter");
        check(32'(integer_feedback_ratio),
            four ? {mb('h46d), mb('h46c), mb('h46b)} + 1 : 0, "int ratio");
        check(32'(fractional_numerator), four ? {mb('h470), mb('h46f), mb('h46e)} : 0, "num");
        check(32'(fractional_modulus), four ? {mb('h473), mb('h472), mb('h471)} : 0, "mod");
    endtask

    // ============================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, other_ref_enable, other_ref_priority} = '0;
        seed_ret = $urandom(32'h5e67_562e);
        for (int i = 'h466; i <= 'h474; i++) idx_list.push_back(i);
        idx_list = {idx_list, 'h4ff, 'h500, 'h51e, 'h51f, 'h52f, 'h530, 'h53e, 'h53f};
        idx_list = {idx_list, 'h540, 'h54d, 'h559, 'h55a};
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        // reset values, mirror edges and holes either side
        foreach (idx_list[k]) check_reg(idx_list[k]);
        check_sel();
        // all ones: reserved bits must read back zero
        foreach (idx_list[k]) bus_write(idx_list[k], 8'hff, 1'b1);
        foreach (idx_list[k]) check_reg(idx_list[k]);
        check_sel();
        // random traffic, some with the byte strobe low
        repeat (80) begin
            idx = idx_list[$urandom % idx_list.size()];
            bus_write(idx, 8'($urandom), ($urandom % 4) != 0);
            check_reg(idx);
            @(posedge ref_clk);
            other_ref_enable <= 3'($urandom);
            other_ref_priority <= 6'($urandom);
            check_sel();
        end
        // every priority code of the fourth reference against fixed rivals
        @(posedge ref_clk);
        other_ref_enable <= 3'b111;
        other_ref_priority <= 6'b10_01_11;
        // a profile as software should program it: 1 kHz, high margin filter
        bus_write('h468, 8'h10, 1'b1);
        bus_write('h469, 8'h27, 1'b1);
        bus_write('h46a, 8'h02, 1'b1);
        for (int p = 0; p < 4; p++) begin
            bus_write('h467, 8'((p << 1) | 1), 1'b1);
            check_sel();
        end
        bus_write('h467, 8'h00, 1'b1);
        check_sel();
        // second reset in mid-run clears every store
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        mdl.delete();
        foreach (idx_list[k]) check_reg(idx_list[k]);
        check_sel();
        results();
    end
endmodule
